/* hdl/t2cc_regs.vh */
// Register map, field positions and reset values of the timer 2 capture/compare unit
`ifndef T2CC_REGS_VH
`define T2CC_REGS_VH
`define ADDR_W 6
`define OFF_CAPTURE_EDGE_CONTROL 6'h00
`define OFF_COMPARE_SET_ENABLE 6'h04
`define OFF_COMPARE_RESET_TOGGLE_ENABLE 6'h08
`define OFF_TIMER_EVENT_FLAGS 6'h0c
`define OFF_EXTENDED_IRQ_ENABLE 6'h10
`define OFF_COMPARE0_VALUE 6'h14
`define OFF_COMPARE1_VALUE 6'h18
`define OFF_COMPARE2_VALUE 6'h1c
`define OFF_CAPTURE0_VALUE 6'h20
`define OFF_CAPTURE1_VALUE 6'h24
`define OFF_CAPTURE2_VALUE 6'h28
`define OFF_CAPTURE3_VALUE 6'h2c
`define OFF_PORT4_STATE 6'h30
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RST_PINS 6'h00
`define RST_TGL 2'h0
`define RST_FLAGS 7'h00
`define RST_MATCH 3'h0
`define RST_DATA 32'h0000_0000
`define FLD_BYTE0 7:0
`define FLD_BYTE1 15:8
`define FLD_EVENTS 6:0
`define FLD_CMP_FLAGS 6:4
`define FLD_CAP_FLAGS 3:0
`define FLD_TGL 7:6
`define FLD_PINS 5:0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hdl/capture_channel.v */
// One capture channel: edge detect, timer snapshot
`timescale 1ns/1ps
module capture_channel #(
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire pin,
  input wire rise_en,
  input wire fall_en,
  input wire [TW-1:0] timer_value,
  output reg [TW-1:0] value_q,
  output wire event_p
);
`include "t2cc_regs.vh"
  reg pin_q;
  assign event_p = ce & ((rise_en & pin & ~pin_q) | (fall_en & ~pin & pin_q));
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b0;
      value_q <= `RST_WORD;
    end else if (ce) begin
      pin_q <= pin;
      if (event_p) begin
        value_q <= timer_value;
      end
    end
  end
endmodule

/* hdl/compare_channel.v */
// One compare channel: match on a timer increment while the timer equals the compare value
`timescale 1ns/1ps
module compare_channel #(
  parameter TW = 16
) (
  input wire [TW-1:0] timer_value,
  input wire timer_inc,
  input wire [TW-1:0] compare_value,
  output wire match_p
);
  assign match_p = timer_inc & (timer_value == compare_value);
endmodule

/* hdl/timer2_capture_compare_outputs.v */
// Timer 2 capture/compare unit with AXI4-Lite register slave
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Two edge-arm bits per capture channel
// - Armed edge copies 16-bit timer value
// - Capture edge sets flag, gated interrupt
// - Compare each timer increment with pairs
// - Match flag set two cycles later
// - Compare interrupt needs enable bits 6:4
// - Compare 0 sets enabled pins 0-5
// - Compare 1 clears enabled pins 0-5
// - Compare 2 toggles pins 6, 7
// - Toggle flops drive pins, read in set-enable
// - Each toggle flop follows own enable
// - Zero enable bit disables pin action
// - Set-enable bits 5:0 map to pins
// - Reset/toggle-enable bit mapping
module timer2_capture_compare_outputs #(
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire [TW-1:0] timer_value,
  input wire timer_inc,
  input wire capture0_input_pin,
  input wire capture1_input_pin,
  input wire capture2_input_pin,
  input wire capture3_input_pin,
  output reg [7:0] port4_out_q,
  output reg [6:0] irq_req_q,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
`include "t2cc_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// Reset release
  reg rst_s1_q;
  reg rst_n;
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Registers
  reg [7:0] capture_edge_control_q;
  reg [5:0] set_pins_q;
  reg [7:0] compare_reset_toggle_enable_q;
  reg [6:0] timer_event_flags_q;
  reg [6:0] extended_irq_enable_q;
  reg [TW-1:0] compare0_value_q;
  reg [TW-1:0] compare1_value_q;
  reg [TW-1:0] compare2_value_q;
  reg [1:0] toggle_q;
  reg [2:0] match_q;
  wire [3:0] cap_pins;
  wire [3:0] cap_event;
  wire [TW-1:0] cap_val [0:3];
  wire [2:0] match_p;
  wire [7:0] compare_set_enable;
  assign cap_pins = {capture3_input_pin, capture2_input_pin, capture1_input_pin,
                     capture0_input_pin};
  assign compare_set_enable = {toggle_q, set_pins_q};
////////////////////////////////////////////////////////////////////////////////
// Capture and compare channels
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cap
      capture_channel #(.TW(TW)) u_cap (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .pin(cap_pins[gi]),
        .rise_en(capture_edge_control_q[2*gi]),
        .fall_en(capture_edge_control_q[2*gi+1]),
        .timer_value(timer_value),
        .value_q(cap_val[gi]),
        .event_p(cap_event[gi])
      );
    end
  endgenerate
  compare_channel #(.TW(TW)) u_cmp0 (
    .timer_value(timer_value),
    .timer_inc(timer_inc & ce),
    .compare_value(compare0_value_q),
    .match_p(match_p[0])
  );
  compare_channel #(.TW(TW)) u_cmp1 (
    .timer_value(timer_value),
    .timer_inc(timer_inc & ce),
    .compare_value(compare1_value_q),
    .match_p(match_p[1])
  );
  compare_channel #(.TW(TW)) u_cmp2 (
    .timer_value(timer_value),
    .timer_inc(timer_inc & ce),
    .compare_value(compare2_value_q),
    .match_p(match_p[2])
  );
////////////////////////////////////////////////////////////////////////////////
// Bus decode
  wire wr_go;
  wire rd_go;
  wire [5:0] wa;
  reg [31:0] rd_d;
  reg rd_ok;
  reg wr_ok;
  reg [6:0] flag_clr;
  // No new take while a ready pulse or a response still stands
  assign wr_go = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_go = ce & s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign wa = s_axi_awaddr;
  always @* begin
    wr_ok = 1'b1;
    if (wa == `OFF_CAPTURE_EDGE_CONTROL) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_COMPARE_SET_ENABLE) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_COMPARE_RESET_TOGGLE_ENABLE) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_TIMER_EVENT_FLAGS) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_EXTENDED_IRQ_ENABLE) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_COMPARE0_VALUE || wa == `OFF_COMPARE1_VALUE) begin
      wr_ok = 1'b1;
    end else if (wa == `OFF_COMPARE2_VALUE) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
    // Write-one-to-clear on the event flags
    flag_clr = 7'h00;
    if (wr_go && wa == `OFF_TIMER_EVENT_FLAGS && s_axi_wstrb[0]) begin
      flag_clr = s_axi_wdata[6:0];
    end
  end
  always @* begin
    rd_ok = 1'b1;
    rd_d = 32'h0000_0000;
    if (s_axi_araddr == `OFF_CAPTURE_EDGE_CONTROL) begin
      rd_d[7:0] = capture_edge_control_q;
    end else if (s_axi_araddr == `OFF_COMPARE_SET_ENABLE) begin
      rd_d[7:0] = compare_set_enable;
    end else if (s_axi_araddr == `OFF_COMPARE_RESET_TOGGLE_ENABLE) begin
      rd_d[7:0] = compare_reset_toggle_enable_q;
    end else if (s_axi_araddr == `OFF_TIMER_EVENT_FLAGS) begin
      rd_d[6:0] = timer_event_flags_q;
    end else if (s_axi_araddr == `OFF_EXTENDED_IRQ_ENABLE) begin
      rd_d[6:0] = extended_irq_enable_q;
    end else if (s_axi_araddr == `OFF_COMPARE0_VALUE) begin
      rd_d[TW-1:0] = compare0_value_q;
    end else if (s_axi_araddr == `OFF_COMPARE1_VALUE) begin
      rd_d[TW-1:0] = compare1_value_q;
    end else if (s_axi_araddr == `OFF_COMPARE2_VALUE) begin
      rd_d[TW-1:0] = compare2_value_q;
    end else if (s_axi_araddr == `OFF_CAPTURE0_VALUE) begin
      rd_d[TW-1:0] = cap_val[0];
    end else if (s_axi_araddr == `OFF_CAPTURE1_VALUE) begin
      rd_d[TW-1:0] = cap_val[1];
    end else if (s_axi_araddr == `OFF_CAPTURE2_VALUE) begin
      rd_d[TW-1:0] = cap_val[2];
    end else if (s_axi_araddr == `OFF_CAPTURE3_VALUE) begin
      rd_d[TW-1:0] = cap_val[3];
    end else if (s_axi_araddr == `OFF_PORT4_STATE) begin
      rd_d[7:0] = port4_out_q;
    end else begin
      rd_ok = 1'b0;
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Bus handshake: ready pulses on the taking edge, response one edge later
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= `RST_DATA;
    end else if (ce) begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      s_axi_arready <= rd_go;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      // Response only after the address and data handshake edge
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rd_go) begin
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      capture_edge_control_q <= `RST_BYTE;
      set_pins_q <= `RST_PINS;
      compare_reset_toggle_enable_q <= `RST_BYTE;
      extended_irq_enable_q <= `RST_FLAGS;
      compare0_value_q <= `RST_WORD;
      compare1_value_q <= `RST_WORD;
      compare2_value_q <= `RST_WORD;
    end else if (wr_go) begin
      // Low lane holds the byte registers and compare low bytes
      if (s_axi_wstrb[0]) begin
        if (wa == `OFF_CAPTURE_EDGE_CONTROL) begin
          capture_edge_control_q <= s_axi_wdata[`FLD_BYTE0];
        end else if (wa == `OFF_COMPARE_SET_ENABLE) begin
          set_pins_q <= s_axi_wdata[`FLD_PINS];
        end else if (wa == `OFF_COMPARE_RESET_TOGGLE_ENABLE) begin
          compare_reset_toggle_enable_q <= s_axi_wdata[`FLD_BYTE0];
        end else if (wa == `OFF_EXTENDED_IRQ_ENABLE) begin
          extended_irq_enable_q <= s_axi_wdata[`FLD_EVENTS];
        end else if (wa == `OFF_COMPARE0_VALUE) begin
          compare0_value_q[`FLD_BYTE0] <= s_axi_wdata[`FLD_BYTE0];
        end else if (wa == `OFF_COMPARE1_VALUE) begin
          compare1_value_q[`FLD_BYTE0] <= s_axi_wdata[`FLD_BYTE0];
        end else if (wa == `OFF_COMPARE2_VALUE) begin
          compare2_value_q[`FLD_BYTE0] <= s_axi_wdata[`FLD_BYTE0];
        end
      end
      if (s_axi_wstrb[1]) begin
        if (wa == `OFF_COMPARE0_VALUE) begin
          compare0_value_q[`FLD_BYTE1] <= s_axi_wdata[`FLD_BYTE1];
        end else if (wa == `OFF_COMPARE1_VALUE) begin
          compare1_value_q[`FLD_BYTE1] <= s_axi_wdata[`FLD_BYTE1];
        end else if (wa == `OFF_COMPARE2_VALUE) begin
          compare2_value_q[`FLD_BYTE1] <= s_axi_wdata[`FLD_BYTE1];
        end
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
// Flags, interrupt requests and port-4 outputs
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_q <= `RST_MATCH;
      timer_event_flags_q <= `RST_FLAGS;
      irq_req_q <= `RST_FLAGS;
      port4_out_q <= `RST_BYTE;
      toggle_q <= `RST_TGL;
    end else if (ce) begin
      match_q <= match_p;
      // Set beats clear; compare flags land two cycles after the match
      timer_event_flags_q[`FLD_CAP_FLAGS] <= (timer_event_flags_q[`FLD_CAP_FLAGS] &
        ~flag_clr[`FLD_CAP_FLAGS]) | cap_event;
      timer_event_flags_q[`FLD_CMP_FLAGS] <= (timer_event_flags_q[`FLD_CMP_FLAGS] &
        ~flag_clr[`FLD_CMP_FLAGS]) | match_q;
      // Requests follow the flags one cycle later
      irq_req_q <= timer_event_flags_q & extended_irq_enable_q;
      // Set first, then reset, so reset wins
      port4_out_q[`FLD_PINS] <= (port4_out_q[`FLD_PINS] |
        ({6{match_p[0]}} & set_pins_q)) &
        ~({6{match_p[1]}} & compare_reset_toggle_enable_q[`FLD_PINS]);
      // Toggle flops, not the pin latch, hold pins 7:6
      toggle_q <= toggle_q ^ ({2{match_p[2]}} &
        compare_reset_toggle_enable_q[`FLD_TGL]);
      port4_out_q[`FLD_TGL] <= toggle_q ^ ({2{match_p[2]}} &
        compare_reset_toggle_enable_q[`FLD_TGL]);
    end
  end
endmodule

/* dv/t2cc_props.sv */
// Port-level assertions for the timer 2 capture/compare unit
`timescale 1ns/1ps
module t2cc_props #(
  parameter TW = 16
) (
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire timer_inc,
  input wire [7:0] port4_out_q,
  input wire [6:0] irq_req_q,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn || !ce);
  a_set_after_inc: assert property (|(port4_out_q[5:0] & ~$past(port4_out_q[5:0]))
    |-> $past(timer_inc)) else $error("pin set without timer step");
  a_clr_after_inc: assert property (|(~port4_out_q[5:0] & $past(port4_out_q[5:0]))
    |-> $past(timer_inc)) else $error("pin cleared without timer step");
  a_tgl_after_inc: assert property (!$stable(port4_out_q[7:6]) |-> $past(timer_inc))
    else $error("toggle flop moved without timer step");
  a_cmp_irq_delay: assert property (|(irq_req_q[6:4] & ~$past(irq_req_q[6:4]))
    |-> $past(timer_inc, 3) || $past(s_axi_wvalid, 2))
    else $error("compare request not three cycles after step");
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
    && !s_axi_bvalid |=> s_axi_awready ##1 s_axi_bvalid)
    else $error("write not taken and answered in order");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready ##1 s_axi_rvalid) else $error("read not taken and answered in order");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind timer2_capture_compare_outputs t2cc_props #(.TW(TW)) u_t2cc_props (.clk_sys, .rstn,
  .ce, .timer_inc, .port4_out_q, .irq_req_q, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

/* dv/capture_pin_model.sv */
// Far-side model driving the capture input pins
`timescale 1ns/1ps
module capture_pin_model (
  input wire clk_sys,
  input wire [3:0] level_req,
  output reg [3:0] pins_q
);
  initial pins_q = 4'h0;
  always @(posedge clk_sys) begin
    pins_q <= level_req;
  end
endmodule

/* dv/timer2_capture_compare_outputs_tb.sv */
// Self-checking bench for the timer 2 capture/compare unit
`timescale 1ns/1ps
`include "t2cc_regs.vh"
module timer2_capture_compare_outputs_tb;
  reg clk_sys = 0, rstn = 0, timer_inc = 0;
  reg [15:0] timer_value = 0, cap;
  reg [3:0] lvl = 0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg ce = 1;
  reg [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  reg [31:0] s_axi_wdata = 0, v, se, rt, ie;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] pins;
  wire [7:0] port4_out_q;
  wire [6:0] irq_req_q;
  reg [7:0] p;
  reg [2:0] h, fl;
  integer n, e, k, cyc = 0, mismatches = 0, checks_done = 0;
  initial forever #2 clk_sys = ~clk_sys;
  capture_pin_model u_capture_pin_model (.clk_sys, .level_req(lvl), .pins_q(pins));
  timer2_capture_compare_outputs u_timer2_capture_compare_outputs (.clk_sys, .rstn, .ce,
    .timer_value, .timer_inc, .capture0_input_pin(pins[0]), .capture1_input_pin(pins[1]),
    .capture2_input_pin(pins[2]), .capture3_input_pin(pins[3]), .port4_out_q, .irq_req_q,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [34:0] g, input [34:0] x);
    checks_done = checks_done + 1;
    if (g !== x) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task wr(input [5:0] a, input [31:0] d, input [1:0] er);
    integer i;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
  endtask
  task rd(input [5:0] a, input [31:0] x, input [1:0] er);
    integer i;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, x});
  endtask
  task tick(input [15:0] t);
    @(posedge clk_sys);
    timer_value <= t;
    timer_inc <= 1'b1;
    @(posedge clk_sys);
    timer_inc <= 1'b0;
  endtask
  function [31:0] rw_mask(input [5:0] a);
    case (a)
      `OFF_COMPARE_SET_ENABLE: rw_mask = 32'h3f;
      `OFF_EXTENDED_IRQ_ENABLE: rw_mask = 32'h7f;
      `OFF_TIMER_EVENT_FLAGS: rw_mask = 32'h0;
      default: rw_mask = (a < 6'h14) ? 32'hff : 32'hffff;
    endcase
  endfunction
  function [7:0] nxt(input [7:0] q, input [2:0] m, input [7:0] s, input [7:0] r);
    nxt = q;
    if (m[0]) nxt[5:0] = nxt[5:0] | s[5:0];
    if (m[1]) nxt[5:0] = nxt[5:0] & ~r[5:0];
    if (m[2]) nxt[7:6] = nxt[7:6] ^ r[7:6];
  endfunction
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'hbfa8836b);
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    for (n = 0; n < 13; n++) rd(6'(4 * n), 0, `RESP_OKAY);
    rd(6'h34, 0, `RESP_SLVERR);
    wr(6'h34, 32'h1, `RESP_SLVERR);
    wr(`OFF_CAPTURE0_VALUE, 32'hffff, `RESP_SLVERR);
    for (n = 0; n < 8; n++) begin
      v = $urandom;
      wr(6'(4 * n), v, `RESP_OKAY);
      rd(6'(4 * n), v & rw_mask(6'(4 * n)), `RESP_OKAY);
    end
    s_axi_wstrb <= 4'h2;
    wr(`OFF_COMPARE2_VALUE, 32'h0000_5aa5, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`OFF_COMPARE2_VALUE, {16'h0000, 8'h5a, v[7:0]}, `RESP_OKAY);
    $display("test registers done");
    for (n = 0; n < 4; n++) begin
      wr(`OFF_EXTENDED_IRQ_ENABLE, n[0] ? 32'h0 : 32'hf, `RESP_OKAY);
      cap = 0;
      for (e = 0; e < 4; e++) begin
        wr(`OFF_CAPTURE_EDGE_CONTROL, 32'h1 << (2 * n + e / 2), `RESP_OKAY);
        v = $urandom;
        timer_value <= v[15:0];
        lvl[n] <= ~e[0];
        k = (e == 0 || e == 3);
        if (k) cap = v[15:0];
        repeat (6) @(posedge clk_sys);
        chk(irq_req_q, (k && !n[0]) << n);
        rd(`OFF_CAPTURE0_VALUE + 6'(4 * n), cap, `RESP_OKAY);
        rd(`OFF_TIMER_EVENT_FLAGS, k << n, `RESP_OKAY);
        wr(`OFF_TIMER_EVENT_FLAGS, 32'hf, `RESP_OKAY);
      end
    end
    $display("test capture done");
    p = 0;
    for (n = 0; n < 6; n++) begin
      se = $urandom;
      rt = $urandom;
      v = $urandom;
      ie = n[0] ? 32'h0f : 32'h7f;
      wr(`OFF_EXTENDED_IRQ_ENABLE, ie, `RESP_OKAY);
      wr(`OFF_COMPARE_SET_ENABLE, se, `RESP_OKAY);
      wr(`OFF_COMPARE_RESET_TOGGLE_ENABLE, rt, `RESP_OKAY);
      wr(`OFF_COMPARE0_VALUE, v[15:0], `RESP_OKAY);
      wr(`OFF_COMPARE1_VALUE, v[15:0] + (n == 5 ? 0 : 1), `RESP_OKAY);
      wr(`OFF_COMPARE2_VALUE, v[15:0] + 2, `RESP_OKAY);
      fl = 0;
      for (k = 0; k < 4; k++) begin
        h = {k == 2, k == (n == 5 ? 0 : 1), k == 0};
        fl = fl | h;
        p = nxt(p, h, se[7:0], rt[7:0]);
        tick(v[15:0] + 16'(k));
        @(posedge clk_sys);
        chk(port4_out_q, p);
      end
      rd(`OFF_COMPARE_SET_ENABLE, {p[7:6], se[5:0]}, `RESP_OKAY);
      rd(`OFF_TIMER_EVENT_FLAGS, {fl, 4'h0}, `RESP_OKAY);
      chk(irq_req_q, {fl & ie[6:4], 4'h0});
      wr(`OFF_TIMER_EVENT_FLAGS, 32'h70, `RESP_OKAY);
    end
    $display("test compare done");
    wr(`OFF_COMPARE_RESET_TOGGLE_ENABLE, 32'hc0, `RESP_OKAY);
    for (k = 0; k < 2; k++) begin
      ce <= k[0];
      tick(v[15:0] + 16'h0002);
      @(posedge clk_sys);
      if (k == 1) p = nxt(p, 3'h4, 8'h00, 8'hc0);
      chk(port4_out_q, p);
    end
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({port4_out_q, irq_req_q}, 15'h0000);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(`OFF_COMPARE_SET_ENABLE, 32'h0, `RESP_OKAY);
    $display("test freeze and reset done");
    results;
  end
endmodule
